// *** rqrl_pkg.sv ***
// Package: constants, commands and carrier types for the remote query and range hold block
package rqrl_pkg;
  localparam int   MAX_RESP     = 64;
  localparam int   HDR_LEN      = 4;
  localparam int   MAX_DATA     = MAX_RESP - HDR_LEN;
  localparam int   NAME_LEN     = 8;
  localparam [7:0] CH_HASH      = 8'h23;
  localparam [7:0] CH_ZERO      = 8'h30;
  localparam [7:0] CH_NINE      = 8'h39;
  localparam [7:0] CH_SPACE     = 8'h20;
  localparam [7:0] NUM_DIGITS   = 8'h02;
  localparam [6:0] TEN          = 7'h0A;

  typedef enum logic [1:0]
  {
    CMD_USER_QUERY  = 2'h0,
    CMD_RANGE_QUERY = 2'h1,
    CMD_RANGE_HOLD  = 2'h2,
    CMD_NONE        = 2'h3
  } rqrl_cmd_type;

  typedef struct packed
  {
    rqrl_cmd_type cmd;
    logic         hold_on;
  } rqrl_req_type;

  typedef struct packed
  {
    logic [7:0] data;
    logic       last;
  } rqrl_char_type;
endpackage

// *** rqrl_mem.sv ***
// Protected user memory: byte array with a registered read port
`timescale 1ns/10ps
module rqrl_mem #(
  parameter int DEPTH = rqrl_pkg::MAX_DATA
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
  input  wire logic [7:0]               i_wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
  output logic      [7:0]               o_rd_data
);
  logic [7:0] mem_ff [DEPTH];

  // No reset on the array so it maps onto plain RAM
  always_ff @(posedge i_sys_clk)
  begin
    if (i_wr_en)
    begin
      mem_ff[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem_ff[i_rd_addr];
  end
endmodule

// *** rqrl_top.sv ***
// Command interpreter for user data query, range query and range hold
`timescale 1ns/10ps
module rqrl_top #(
  parameter int DEPTH = rqrl_pkg::MAX_DATA
) (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_rst_b,
  input  wire logic                           i_req_valid,
  input  wire rqrl_pkg::rqrl_req_type         i_req,
  output logic                                o_req_ready,
  input  wire logic                           i_remote,
  input  wire logic [1:0]                     i_function,
  input  wire logic [8*rqrl_pkg::NAME_LEN-1:0] i_range_name,
  input  wire logic [6:0]                     i_user_len,
  input  wire logic                           i_mem_wr_en,
  input  wire logic [$clog2(DEPTH)-1:0]       i_mem_wr_addr,
  input  wire logic [7:0]                     i_mem_wr_data,
  output logic                                o_resp_valid,
  output rqrl_pkg::rqrl_char_type             o_resp,
  input  wire logic                           i_resp_ready,
  output logic                                o_range_locked
);
  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'b0001,
    ST_HDR   = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_NAME  = 4'b1000
  } rqrl_state_type;

  rqrl_state_type      state_ff;
  logic [6:0]          idx_ff;
  logic [6:0]          len_ff;
  logic [1:0]          func_ff;
  logic [7:0]          rd_data;
  logic                rd_wait_ff;
  logic [8*rqrl_pkg::NAME_LEN-1:0] name_ff;
  logic                take;
  logic                adv;
  logic [6:0]          clip_len;

  function automatic logic [7:0] digit(input logic [6:0] v);
    digit = rqrl_pkg::CH_ZERO + {4'h0, v[3:0]};
  endfunction

  // Length clipped so header plus data stay within the response limit
  assign clip_len = (i_user_len > 7'(DEPTH)) ? 7'(DEPTH) : i_user_len;
  assign take     = i_req_valid && o_req_ready;
  assign adv      = o_resp_valid && i_resp_ready;

  rqrl_mem #(.DEPTH(DEPTH)) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_wr_en   (i_mem_wr_en),
    .i_wr_addr (i_mem_wr_addr),
    .i_wr_data (i_mem_wr_data),
    .i_rd_addr (idx_ff[$clog2(DEPTH)-1:0]),
    .o_rd_data (rd_data)
  );

  // Ready only in idle: queries block parsing until their answer is gone
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_ff     <= ST_IDLE;
      idx_ff       <= 7'h00;
      len_ff       <= 7'h00;
      name_ff      <= '0;
      rd_wait_ff   <= 1'b0;
      o_req_ready  <= 1'b1;
      o_resp_valid <= 1'b0;
      o_resp       <= '0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (take && i_req.cmd == rqrl_pkg::CMD_USER_QUERY)
          begin
            state_ff     <= ST_HDR;
            o_req_ready  <= 1'b0;
            len_ff       <= clip_len;
            idx_ff       <= 7'h00;
            o_resp_valid <= 1'b1;
            o_resp       <= '{data: rqrl_pkg::CH_HASH, last: 1'b0};
          end
          else if (take && i_req.cmd == rqrl_pkg::CMD_RANGE_QUERY)
          begin
            state_ff     <= ST_NAME;
            o_req_ready  <= 1'b0;
            name_ff      <= i_range_name << 8;
            idx_ff       <= 7'h01;
            o_resp_valid <= 1'b1;
            o_resp       <= '{data: i_range_name[8*rqrl_pkg::NAME_LEN-1 -: 8],
                              last: 1'b0};
          end
        end
        ST_HDR:
        begin
          if (adv)
          begin
            idx_ff <= idx_ff + 7'h01;
            if (idx_ff == 7'h00)
            begin
              o_resp.data <= rqrl_pkg::CH_ZERO + rqrl_pkg::NUM_DIGITS;
            end
            else if (idx_ff == 7'h01)
            begin
              o_resp.data <= digit(len_ff / rqrl_pkg::TEN);
            end
            else
            begin
              o_resp.data <= digit(len_ff % rqrl_pkg::TEN);
              o_resp.last <= (len_ff == 7'h00);
              if (len_ff == 7'h00)
              begin
                state_ff <= ST_DATA;
                idx_ff   <= len_ff;
              end
              else
              begin
                state_ff <= ST_DATA;
                idx_ff   <= 7'h00;
              end
            end
          end
        end
        ST_DATA:
        begin
          // Memory read has one cycle latency, so valid drops while it lands
          if (rd_wait_ff)
          begin
            rd_wait_ff   <= 1'b0;
            o_resp_valid <= 1'b1;
            o_resp       <= '{data: rd_data, last: (idx_ff + 7'h01 == len_ff)};
            idx_ff       <= idx_ff + 7'h01;
          end
          else if (adv)
          begin
            if (o_resp.last)
            begin
              state_ff     <= ST_IDLE;
              o_resp_valid <= 1'b0;
              o_req_ready  <= 1'b1;
            end
            else
            begin
              o_resp_valid <= 1'b0;
              rd_wait_ff   <= 1'b1;
            end
          end
        end
        ST_NAME:
        begin
          if (adv)
          begin
            if (o_resp.last)
            begin
              state_ff     <= ST_IDLE;
              o_resp_valid <= 1'b0;
              o_req_ready  <= 1'b1;
            end
            else
            begin
              o_resp   <= '{data: name_ff[8*rqrl_pkg::NAME_LEN-1 -: 8],
                            last: (idx_ff == 7'(rqrl_pkg::NAME_LEN - 1))};
              name_ff  <= name_ff << 8;
              idx_ff   <= idx_ff + 7'h01;
            end
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Range hold runs beside any query: accepted even while a query drains
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      func_ff        <= 2'h0;
      o_range_locked <= 1'b0;
    end
    else
    begin
      func_ff <= i_function;
      if (func_ff != i_function)
      begin
        o_range_locked <= 1'b0;
      end
      else if (i_req_valid && i_req.cmd == rqrl_pkg::CMD_RANGE_HOLD && i_remote)
      begin
        o_range_locked <= i_req.hold_on;
      end
    end
  end

  a_hold_sets: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_req_valid && i_req.cmd == rqrl_pkg::CMD_RANGE_HOLD && i_remote
     && func_ff == i_function) |=> (o_range_locked == $past(i_req.hold_on)))
    else $error("range hold not applied");

  a_hold_remote: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (!(i_req_valid && i_req.cmd == rqrl_pkg::CMD_RANGE_HOLD && i_remote)
     && func_ff == i_function) |=> $stable(o_range_locked))
    else $error("range hold changed without remote command");

  a_func_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (func_ff != i_function) |=> !o_range_locked)
    else $error("range lock kept over function change");

  sequence s_hash;
    o_resp_valid && state_ff == ST_HDR && idx_ff == 7'h00;
  endsequence

  a_hdr_hash: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    s_hash |-> o_resp.data == rqrl_pkg::CH_HASH)
    else $error("response does not open with hash");

  sequence s_count;
    o_resp_valid && state_ff == ST_HDR && idx_ff == 7'h01;
  endsequence

  a_user_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_req.cmd == rqrl_pkg::CMD_USER_QUERY) |=> s_hash)
    else $error("user data query produced no header");

  // The digit count must be non-zero, otherwise a host cannot size the count field
  a_hdr_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    s_count |-> (o_resp.data > rqrl_pkg::CH_ZERO && o_resp.data <= rqrl_pkg::CH_NINE))
    else $error("digit count after hash is not a non-zero digit");

  a_hdr_digit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (o_resp_valid && state_ff == ST_HDR && idx_ff != 7'h00)
    |-> (o_resp.data >= rqrl_pkg::CH_ZERO && o_resp.data <= rqrl_pkg::CH_NINE))
    else $error("count character not a decimal digit");

  a_len_limit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    len_ff <= 7'(DEPTH))
    else $error("response exceeds maximum length");

  a_busy_block: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (state_ff != ST_IDLE) |-> !o_req_ready)
    else $error("parser ready during sequential command");

  a_query_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_req.cmd == rqrl_pkg::CMD_RANGE_QUERY) |=> (o_resp_valid && state_ff == ST_NAME))
    else $error("range query produced no response");
endmodule

// *** rqrl_host.sv ***
// Remote controller model: issues commands and collects response characters
`timescale 1ns/10ps
module rqrl_host (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_req_ready,
  input  wire logic                    i_resp_valid,
  input  wire rqrl_pkg::rqrl_char_type i_resp,
  output logic                         o_req_valid,
  output rqrl_pkg::rqrl_req_type       o_req,
  output logic                         o_resp_ready
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  int         ends = 0;
  initial
  begin
    o_req_valid = 1'b0;
    o_req = '{rqrl_pkg::CMD_NONE, 1'b0};
    o_resp_ready = 1'b1;
  end
  // Slow mode stalls every other cycle so characters sent back to back must stand
  always @(posedge i_sys_clk)
  begin
    if (i_resp_valid && o_resp_ready)
    begin
      got.push_back(i_resp.data);
      if (i_resp.last)
        ends++;
    end
    #1 o_resp_ready <= slow ? ~o_resp_ready : 1'b1;
  end
  // Queries wait for ready; range hold is taken on the first edge
  task automatic send(input rqrl_pkg::rqrl_cmd_type cmd, input logic on);
    o_req = '{cmd, on};
    o_req_valid = 1'b1;
    repeat (200)
    begin
      @(posedge i_sys_clk);
      if (i_req_ready || cmd == rqrl_pkg::CMD_RANGE_HOLD)
        break;
    end
    #1;
    o_req_valid = 1'b0;
    o_req = '{rqrl_pkg::CMD_NONE, ~on};
  endtask
endmodule

// *** testbench.sv ***
// Self-checking testbench for the remote query and range hold block
`timescale 1ns/10ps
module testbench;
  logic                    clk;
  logic                    rst_b = 1'b0;
  logic                    req_valid;
  rqrl_pkg::rqrl_req_type  req;
  logic                    req_ready;
  logic                    remote = 1'b1;
  logic [1:0]              func = 2'h0;
  logic [63:0]             range_name = "DC_10V  ";
  logic [6:0]              user_len = 7'h05;
  logic                    wr_en = 1'b0;
  logic [5:0]              wr_addr = 6'h00;
  logic [7:0]              wr_data = 8'h00;
  logic                    resp_valid;
  rqrl_pkg::rqrl_char_type resp;
  logic                    resp_ready;
  logic                    locked;
  int                      miscompares = 0;
  int                      comparisons = 0;
  rqrl_top dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(req_ready), .i_remote(remote), .i_function(func),
    .i_range_name(range_name), .i_user_len(user_len), .i_mem_wr_en(wr_en),
    .i_mem_wr_addr(wr_addr), .i_mem_wr_data(wr_data), .o_resp_valid(resp_valid),
    .o_resp(resp), .i_resp_ready(resp_ready), .o_range_locked(locked));
  rqrl_host host (.i_sys_clk(clk), .i_req_ready(req_ready), .i_resp_valid(resp_valid),
    .i_resp(resp), .o_req_valid(req_valid), .o_req(req), .o_resp_ready(resp_ready));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic string user_exp(input int len);
    string s;
    s = $sformatf("#2%02d", len);
    for (int i = 0; i < len; i++)
      s = $sformatf("%s%c", s, 8'h30 + i);
    return s;
  endfunction
  task automatic query(input rqrl_pkg::rqrl_cmd_type cmd, input string exp);
    int e;
    int n;
    host.got.delete();
    e = host.ends;
    n = 0;
    host.send(cmd, 1'b0);
    chk(req_ready, 0);
    while (host.ends == e && n++ < 400)
      step(1);
    chk(host.ends, e + 1);
    chk(host.got.size(), exp.len());
    foreach (host.got[i]) chk(host.got[i], exp[i]);
    chk(req_ready, 1);
  endtask
  task automatic hold(input logic on, input logic exp);
    host.send(rqrl_pkg::CMD_RANGE_HOLD, on);
    step(1);
    chk(locked, exp);
  endtask
  task automatic func_clear(input logic [1:0] code);
    func = code;
    step(2);
    chk(locked, 0);
  endtask
  task automatic results;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    results();
  end
  initial
  begin
    step(6);
    rst_b = 1'b1;
    for (int i = 0; i < 60; i++)
    begin
      wr_en = 1'b1;
      wr_addr = 6'(i);
      wr_data = 8'h30 + 8'(i);
      step(1);
    end
    wr_en = 1'b0;
    host.slow = 1'b1;
    query(rqrl_pkg::CMD_USER_QUERY, user_exp(5));
    host.slow = 1'b0;
    query(rqrl_pkg::CMD_RANGE_QUERY, "DC_10V  ");
    range_name = "AC_1A   ";
    query(rqrl_pkg::CMD_RANGE_QUERY, "AC_1A   ");
    user_len = 7'h00;
    query(rqrl_pkg::CMD_USER_QUERY, user_exp(0));
    // Oversize length is clipped so the whole reply stays within bounds
    user_len = 7'h7F;
    query(rqrl_pkg::CMD_USER_QUERY, user_exp(60));
    hold(1'b1, 1'b1);
    remote = 1'b0;
    hold(1'b0, 1'b1);
    remote = 1'b1;
    hold(1'b0, 1'b0);
    hold(1'b1, 1'b1);
    func_clear(2'h1);
    user_len = 7'h03;
    host.slow = 1'b1;
    fork
      query(rqrl_pkg::CMD_USER_QUERY, user_exp(3));
      begin
        step(3);
        hold(1'b1, 1'b1);
      end
    join
    results();
  end
endmodule
